// ===== design/usb_slave_regs_defs.svh
// Register offsets, field positions and reset values of the control bank
`ifndef USB_SLAVE_REGS_DEFS_SVH
`define USB_SLAVE_REGS_DEFS_SVH

// Register offsets on the two-step port
`define OFS_MAIN_CONTROL       8'h05
`define OFS_INTERRUPT_MASK     8'h06
`define OFS_DEVICE_BUS_ADDRESS 8'h07
`define OFS_DMA_COUNT_LOW      8'h35
`define OFS_INTERRUPT_PENDING  8'h0D
`define OFS_DMA_COUNT_HIGH     8'h36

// Main control field positions
`define BIT_RESERVED_TOP       7
`define BIT_STANDBY            6
`define BIT_LOW_SPEED          5
`define BIT_FORCE_HI           4
`define BIT_FORCE_LO           3
`define BIT_DMA_DIR            2
`define BIT_DMA_ENABLE         1
`define BIT_USB_ENABLE         0

// Interrupt mask and pending field positions
`define BIT_DMA_PROGRESS       7
`define BIT_EVT_USB_RESET      6
`define BIT_EVT_SOF            5
`define BIT_EVT_DMA_DONE       4
`define EVT_WIDTH              7

// Reset values
`define RST_MAIN_CONTROL       7'h00
`define RST_INTERRUPT_MASK     7'h00
`define RST_DEVICE_BUS_ADDRESS 8'h00
`define RST_INTERRUPT_PENDING  7'h00
`define RST_POINTER            8'h00
`define RST_READ_DATA          8'h00

`endif

// ===== design/usb_slave_regs_pkg.sv
// Types shared by the control and interrupt register bank
package usb_slave_regs_pkg;

  // Microprocessor port pins, all active low except a0 and data
  typedef struct packed {
    logic       cs_n;
    logic       wr_n;
    logic       rd_n;
    logic       a0;
    logic [7:0] data;
  } bus_pins_s;

  // Writable part of the main control register, bit 6 down to bit 0
  typedef struct packed {
    logic transceiver_standby;
    logic low_speed_select;
    logic line_force_hi;
    logic line_force_lo;
    logic dma_read_dir;
    logic dma_enable;
    logic usb_enable;
  } main_ctrl_s;

  // Event strobes from the serial engine, bit 6 down to bit 0
  typedef struct packed {
    logic       usb_reset;
    logic       sof_received;
    logic       dma_done;
    logic [3:0] ep_done;
  } usb_events_s;

  // Forced USB line state
  typedef enum logic [1:0] {
    LINE_NORMAL,
    LINE_SE0,
    LINE_K,
    LINE_J
  } line_state_e;

  // Line drive toward the transceiver
  typedef struct packed {
    logic force_en;
    logic dp;
    logic dm;
  } line_drive_s;

endpackage

// ===== design/usb_slave_regs.sv
// Control, address and interrupt register bank of a USB slave controller
//
// Behaviour
// - Standby bit puts transceiver in low power
// - Suspend only when standby set, enable clear
// - Speed bit: zero full, one low speed
// - Force bits drive normal, SE0, K, J
// - Force bits clear at power-up
// - Direction bit: one reads, zero writes
// - DMA starts on count high byte write
// - USB enable gates traffic, resets to zero
// - Enable bit lets event raise interrupt
// - Mask writes never touch pending bits
// - Mask bits: reset, SOF, DMA, endpoints
// - Bit seven reads DMA in progress
// - DMA progress fall raises no interrupt
// - Device address resets to zero
// - Respond only to stored device address
// - Pending read shows events, one clears
// - Pending bits share mask bit positions
// - Interrupt request output is active high
`timescale 1ns/1ns
`include "usb_slave_regs_defs.svh"

module usb_slave_regs (
  // Clock and reset
  input  logic                             clk,
  input  logic                             sys_rst,
  // Microprocessor port
  input  usb_slave_regs_pkg::bus_pins_s    cpu_pins,
  output logic [7:0]                       cpu_data_out,
  output logic                             cpu_data_oe_n,
  // Serial engine side
  input  usb_slave_regs_pkg::usb_events_s  sie_events,
  input  logic [7:0]                       token_addr,
  input  logic                             token_addr_valid,
  output logic                             addr_match,
  // Control outputs
  output usb_slave_regs_pkg::main_ctrl_s   main_ctrl,
  output logic                             suspend_mode,
  output usb_slave_regs_pkg::line_state_e  line_state,
  output usb_slave_regs_pkg::line_drive_s  line_drive,
  output logic                             dma_start,
  output logic                             dma_in_progress,
  output logic [7:0]                       device_address,
  // Interrupt
  output logic                             interrupt_request_out
);
  import usb_slave_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  // Decode of the two force bits
  function automatic line_state_e force_decode(input logic hi,
                                               input logic lo);
    line_state_e st;
    case ({hi, lo})
      2'b01:   st = LINE_SE0;
      2'b10:   st = LINE_K;
      2'b11:   st = LINE_J;
      default: st = LINE_NORMAL;
    endcase
    return st;
  endfunction
  // Pin levels for a forced line state
  function automatic line_drive_s force_pins(input line_state_e st);
    line_drive_s d;
    case (st)
      LINE_SE0: d = '{force_en: 1'b1, dp: 1'b0, dm: 1'b0};
      LINE_K:   d = '{force_en: 1'b1, dp: 1'b0, dm: 1'b1};
      LINE_J:   d = '{force_en: 1'b1, dp: 1'b1, dm: 1'b0};
      default:  d = '0;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  bus_pins_s          pins_s1_ff;
  bus_pins_s          pins_s2_ff;
  logic               wr_act;
  logic               rd_act;
  logic               wr_act_ff;
  logic               wr_end;
  logic [7:0]         wr_data_ff;
  logic               wr_a0_ff;
  logic               reg_wr;
  logic [7:0]         pointer_ff;
  main_ctrl_s         ctrl_ff;
  logic [6:0]         mask_ff;
  logic [6:0]         pend_ff;
  logic [6:0]         nxt_pend;
  logic [6:0]         pend_clear;
  logic [7:0]         addr_ff;
  logic               dma_act_ff;
  logic               dma_start_ff;
  logic               irq_ff;
  logic               suspend_ff;
  logic               match_ff;
  line_state_e        line_ff;
  line_drive_s        drive_ff;
  logic [7:0]         rd_data_ff;
  logic               oe_n_ff;
  logic [7:0]         rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Microprocessor port
  // Two-stage synchroniser on all port pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_s1_ff <= '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};  // Idle pin levels
      pins_s2_ff <= '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
    end else begin
      pins_s1_ff <= cpu_pins;
      pins_s2_ff <= pins_s1_ff;
    end
  end

  // Strobe qualification
  assign wr_act = ~pins_s2_ff.cs_n & ~pins_s2_ff.wr_n;
  assign rd_act = ~pins_s2_ff.cs_n & ~pins_s2_ff.rd_n;
  assign wr_end = wr_act_ff & ~wr_act;  // Write ends on nWR or nCS rising
  assign reg_wr = wr_end & wr_a0_ff;

  // Capture write data while the strobe is active
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_act_ff  <= 1'b0;
      wr_data_ff <= 8'h00;
      wr_a0_ff   <= 1'b0;
    end else begin
      wr_act_ff <= wr_act;
      if (wr_act) begin
        wr_data_ff <= pins_s2_ff.data;
        wr_a0_ff   <= pins_s2_ff.a0;
      end
    end
  end

  // Address step: a write with a0 low loads the register pointer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pointer_ff <= `RST_POINTER;
    end else if (wr_end && !wr_a0_ff) begin
      pointer_ff <= wr_data_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Main control; top bit is never stored
  // reserved bit dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= `RST_MAIN_CONTROL;
    end else if (reg_wr && pointer_ff == `OFS_MAIN_CONTROL) begin
      ctrl_ff <= wr_data_ff[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_ff <= `RST_INTERRUPT_MASK;
    end else if (reg_wr && pointer_ff == `OFS_INTERRUPT_MASK) begin
      mask_ff <= wr_data_ff[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_ff <= `RST_DEVICE_BUS_ADDRESS;
    end else if (reg_wr && pointer_ff == `OFS_DEVICE_BUS_ADDRESS) begin
      addr_ff <= wr_data_ff;
    end
  end

  always_comb begin
    pend_clear = '0;
    if (reg_wr && pointer_ff == `OFS_INTERRUPT_PENDING) begin
      pend_clear = wr_data_ff[6:0];
    end
    nxt_pend = (pend_ff & ~pend_clear) | sie_events;  // Set wins
  end

  // Pending event flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_ff <= `RST_INTERRUPT_PENDING;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA
  // start on count high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dma_start_ff <= 1'b0;
    end else begin
      dma_start_ff <= reg_wr && pointer_ff == `OFS_DMA_COUNT_HIGH &&
                      ctrl_ff.dma_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dma_act_ff <= 1'b0;
    end else if (dma_start_ff) begin
      dma_act_ff <= 1'b1;
    end else if (sie_events.dma_done) begin
      dma_act_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and control outputs
  // masked request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(pend_ff & mask_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      suspend_ff <= 1'b0;
    end else begin
      suspend_ff <= ctrl_ff.transceiver_standby & ~ctrl_ff.usb_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_ff  <= LINE_NORMAL;
      drive_ff <= '0;
    end else begin
      line_ff  <= force_decode(ctrl_ff.line_force_hi, ctrl_ff.line_force_lo);
      drive_ff <= force_pins(force_decode(ctrl_ff.line_force_hi,
                                          ctrl_ff.line_force_lo));
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      match_ff <= 1'b0;
    end else begin
      match_ff <= token_addr_valid && token_addr == addr_ff &&
                  ctrl_ff.usb_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_mux = 8'h00;
    if (!pins_s2_ff.a0) begin
      rd_mux = pointer_ff;
    end else begin
      case (pointer_ff)
        `OFS_MAIN_CONTROL:       rd_mux = {1'b0, ctrl_ff};
        `OFS_INTERRUPT_MASK:     rd_mux = {dma_act_ff, mask_ff};
        `OFS_DEVICE_BUS_ADDRESS: rd_mux = addr_ff;
        `OFS_INTERRUPT_PENDING:  rd_mux = {dma_act_ff, pend_ff};
        default:                 rd_mux = 8'h00;
      endcase
    end
  end

  // Registered read data and drive enable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_ff <= `RST_READ_DATA;
      oe_n_ff    <= 1'b1;
    end else begin
      rd_data_ff <= rd_mux;
      oe_n_ff    <= ~rd_act;
    end
  end

  // Output connections
  // speed bit passed out
  assign cpu_data_out          = rd_data_ff;
  assign cpu_data_oe_n         = oe_n_ff;
  assign addr_match            = match_ff;
  assign main_ctrl             = ctrl_ff;
  assign suspend_mode          = suspend_ff;
  assign line_state            = line_ff;
  assign line_drive            = drive_ff;
  assign dma_start             = dma_start_ff;
  assign dma_in_progress       = dma_act_ff;
  assign device_address        = addr_ff;
  assign interrupt_request_out = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Write of a given register at a given offset
  sequence wr_at_s(logic [7:0] ofs);
    reg_wr && pointer_ff == ofs;
  endsequence
  // Event arrives and is enabled
  sequence evt_enabled_s;
    |(sie_events & mask_ff);
  endsequence
  pending_set_a: assert property (
    (sie_events[0]) |=> pend_ff[0])
    else $error("Endpoint 0 event lost from pending");
  pending_clear_a: assert property (
    (wr_at_s(`OFS_INTERRUPT_PENDING) and wr_data_ff[5] && !sie_events[5])
    |=> !pend_ff[5])
    else $error("Pending bit not cleared by one write");
  mask_isolate_a: assert property (
    (wr_at_s(`OFS_INTERRUPT_MASK) and sie_events == '0)
    |=> pend_ff == $past(pend_ff))
    else $error("Mask write changed pending bits");
  irq_raise_a: assert property (
    evt_enabled_s |=> ##1 interrupt_request_out)
    else $error("Enabled event did not raise request");
  irq_gate_a: assert property (
    (pend_ff & mask_ff) == '0 |=> !interrupt_request_out)
    else $error("Request high with nothing enabled");
  dma_start_a: assert property (
    dma_start |=> dma_in_progress && $past(ctrl_ff.dma_enable, 2))
    else $error("DMA start without enable or progress");
  dma_quiet_a: assert property (
    ($fell(dma_in_progress) && (pend_ff & mask_ff) == '0 &&
     !mask_ff[4]) |=> !interrupt_request_out)
    else $error("DMA progress fall raised request");
  suspend_qual_a: assert property (
    suspend_mode |-> $past(ctrl_ff.transceiver_standby) &&
                     !$past(ctrl_ff.usb_enable))
    else $error("Suspend entered without standby and disable");
  addr_filter_a: assert property (
    addr_match |-> $past(token_addr) == $past(addr_ff) &&
                   $past(token_addr_valid))
    else $error("Match on a foreign address");
  line_se0_a: assert property (
    (!ctrl_ff.line_force_hi && ctrl_ff.line_force_lo)
    |=> line_drive.force_en && !line_drive.dp && !line_drive.dm)
    else $error("SE0 force not driven");
  reserved_top_a: assert property (
    (wr_at_s(`OFS_MAIN_CONTROL)) |=> ctrl_ff == $past(wr_data_ff[6:0]))
    else $error("Main control write not stored");
endmodule

// ===== sim/cpu_port_model.sv
// Behavioural microprocessor driving the two-step register port
`timescale 1ns/1ns
`include "usb_slave_regs_defs.svh"

module cpu_port_model (
  // Clock
  input  logic                          clk,
  // Port pins toward the device
  output usb_slave_regs_pkg::bus_pins_s pins,
  input  logic [7:0]                    data_out,
  input  logic                          data_oe_n
);
  import usb_slave_regs_pkg::*;

  logic       cs_n = 1'h1;
  logic       wr_n = 1'h1;
  logic       rd_n = 1'h1;
  logic       a0   = 1'h0;
  logic       drv  = 1'h0;
  logic [7:0] wdat = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] level;
  logic [7:0] rdat;

  ////////////////////////////////////////////////////////////
  // Bus level: own drive, device drive, else a moving float
  assign level = drv ? wdat : (!data_oe_n ? data_out : ~last);
  assign pins  = '{cs_n, wr_n, rd_n, a0, level};

  // Last level, so an undriven bus never holds still
  always @(negedge clk) last <= level;

  // One access, low and high phases well past the synchroniser
  task automatic strobe(input logic a, input logic [7:0] d, input logic wr);
    @(negedge clk);
    {cs_n, a0, wdat, drv, wr_n, rd_n} = {1'h0, a, d, wr, ~wr, wr};
    repeat (4) @(negedge clk);
    rdat = level;
    {cs_n, wr_n, rd_n, drv} = 4'hE;
    repeat (5) @(negedge clk);
  endtask

  // Pointer step, then data step
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    strobe(1'h0, ofs, 1'h1);
    strobe(1'h1, (ofs == `OFS_MAIN_CONTROL) ? {1'h0, d[6:0]} : d, 1'h1);
  endtask

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    strobe(1'h0, ofs, 1'h1);
    strobe(1'h1, 8'h00, 1'h0);
    d = rdat;
  endtask

  task automatic start_dma(input logic [7:0] lo, input logic [7:0] hi);
    write_reg(`OFS_DMA_COUNT_LOW, lo);
    write_reg(`OFS_DMA_COUNT_HIGH, hi);
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench of the control and interrupt register bank
`timescale 1ns/1ns
`include "usb_slave_regs_defs.svh"

module testbench;
  import usb_slave_regs_pkg::*;

  // Control setting beside its decoded outputs
  typedef struct packed {
    logic [7:0]  ctl;
    line_state_e st;
    logic [2:0]  drv;
    logic        susp;
  } ctl_row_s;

  localparam int NROWS = 7;
  localparam ctl_row_s ROWS [NROWS] = '{
    '{8'h00, LINE_NORMAL, 3'h0, 1'h0},
    '{8'h08, LINE_SE0,    3'h4, 1'h0},
    '{8'h10, LINE_K,      3'h5, 1'h0},
    '{8'h18, LINE_J,      3'h6, 1'h0},
    '{8'h40, LINE_NORMAL, 3'h0, 1'h1},
    '{8'h41, LINE_NORMAL, 3'h0, 1'h0},
    '{8'h27, LINE_NORMAL, 3'h0, 1'h0}
  };

  logic        clk              = 1'h0;
  logic        sys_rst          = 1'h1;
  bus_pins_s   cpu_pins;
  logic [7:0]  cpu_data_out;
  logic        cpu_data_oe_n;
  usb_events_s sie_events       = 7'h00;
  logic [7:0]  token_addr       = 8'h00;
  logic        token_addr_valid = 1'h0;
  logic        addr_match;
  main_ctrl_s  main_ctrl;
  logic        suspend_mode;
  line_state_e line_state;
  line_drive_s line_drive;
  logic        dma_start;
  logic        dma_in_progress;
  logic [7:0]  device_address;
  logic        interrupt_request_out;
  int          n_errors = 0;
  int          n_tests  = 0;
  int          n_starts = 0;
  int          cycles   = 0;
  logic [7:0]  rd;
  logic [7:0]  m;

  usb_slave_regs i_usb_slave_regs (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .cpu_pins              (cpu_pins),
    .cpu_data_out          (cpu_data_out),
    .cpu_data_oe_n         (cpu_data_oe_n),
    .sie_events            (sie_events),
    .token_addr            (token_addr),
    .token_addr_valid      (token_addr_valid),
    .addr_match            (addr_match),
    .main_ctrl             (main_ctrl),
    .suspend_mode          (suspend_mode),
    .line_state            (line_state),
    .line_drive            (line_drive),
    .dma_start             (dma_start),
    .dma_in_progress       (dma_in_progress),
    .device_address        (device_address),
    .interrupt_request_out (interrupt_request_out)
  );

  cpu_port_model i_cpu_port_model (
    .clk       (clk),
    .pins      (cpu_pins),
    .data_out  (cpu_data_out),
    .data_oe_n (cpu_data_oe_n)
  );

  ////////////////////////////////////////////////////////////
  // 250 MHz clock
  always #2 clk = ~clk;

  // Start pulse count and hang guard
  always @(posedge clk) begin
    cycles++;
    if (dma_start === 1'h1) n_starts++;
    if (cycles == 6000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_check(input string name, input logic [7:0] ofs,
                          input logic [7:0] exp);
    i_cpu_port_model.read_reg(ofs, rd);
    check(name, exp, rd);
  endtask

  // One-cycle event pulse, then room for the request to settle
  task automatic pulse(input logic [6:0] ev);
    @(negedge clk);
    sie_events = ev;
    @(negedge clk);
    sie_events = 7'h00;
    repeat (2) @(negedge clk);
  endtask

  task automatic token(input logic [7:0] a, input logic exp);
    @(negedge clk);
    {token_addr, token_addr_valid} = {a, 1'h1};
    @(negedge clk);
    token_addr_valid = 1'h0;
    check("addr_match", 8'(exp), 8'(addr_match));
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'h0;
    // Reset state
    check("ctl_rst", 8'h00, {1'h0, main_ctrl});
    check("line_rst", 8'(LINE_NORMAL), 8'(line_state));
    check("irq_rst", 8'h00, 8'(interrupt_request_out));
    check("addr_rst", 8'h00, device_address);
    rd_check("addr_rd", `OFS_DEVICE_BUS_ADDRESS, 8'h00);
    // Control table
    for (int i = 0; i < NROWS; i++) begin
      i_cpu_port_model.write_reg(`OFS_MAIN_CONTROL, ROWS[i].ctl);
      check("ctl", ROWS[i].ctl, {1'h0, main_ctrl});
      check("line", 8'(ROWS[i].st), 8'(line_state));
      check("force", 8'(ROWS[i].drv[2]), 8'(line_drive.force_en));
      check("dp_dm", 8'(ROWS[i].drv[1:0]),
            8'({line_drive.dp, line_drive.dm}));
      check("suspend", 8'(ROWS[i].susp), 8'(suspend_mode));
      rd_check("ctl_rd", `OFS_MAIN_CONTROL, ROWS[i].ctl);
    end
    // Address register and token match, USB enabled
    i_cpu_port_model.write_reg(`OFS_DEVICE_BUS_ADDRESS, 8'hA5);
    rd_check("addr", `OFS_DEVICE_BUS_ADDRESS, 8'hA5);
    check("dev_addr", 8'hA5, device_address);
    token(8'hA5, 1'h1);
    token(8'hA4, 1'h0);
    token(8'h25, 1'h0);
    rd_check("unmapped", 8'h08, 8'h00);
    // Every event through mask, pending and clear
    for (int i = 0; i < 7; i++) begin
      m = 8'h01 << i;
      i_cpu_port_model.write_reg(`OFS_INTERRUPT_MASK, m);
      pulse(m[6:0]);
      check("irq_on", 8'h01, 8'(interrupt_request_out));
      rd_check("pending", `OFS_INTERRUPT_PENDING, m);
      rd_check("mask", `OFS_INTERRUPT_MASK, m);
      i_cpu_port_model.write_reg(`OFS_INTERRUPT_PENDING, ~m & 8'h7F);
      i_cpu_port_model.write_reg(`OFS_INTERRUPT_MASK, 8'h00);
      check("irq_off", 8'h00, 8'(interrupt_request_out));
      rd_check("kept", `OFS_INTERRUPT_PENDING, m);
      i_cpu_port_model.write_reg(`OFS_INTERRUPT_PENDING, m);
      rd_check("cleared", `OFS_INTERRUPT_PENDING, 8'h00);
    end
    // DMA start gated by enable, progress bit, silent completion
    i_cpu_port_model.write_reg(`OFS_MAIN_CONTROL, 8'h01);
    i_cpu_port_model.start_dma(8'h10, 8'h00);
    check("no_start", 8'h00, 8'(n_starts));
    i_cpu_port_model.write_reg(`OFS_MAIN_CONTROL, 8'h03);
    i_cpu_port_model.start_dma(8'h10, 8'h00);
    check("starts", 8'h01, 8'(n_starts));
    rd_check("busy_pend", `OFS_INTERRUPT_PENDING, 8'h80);
    rd_check("busy_mask", `OFS_INTERRUPT_MASK, 8'h80);
    i_cpu_port_model.write_reg(`OFS_INTERRUPT_MASK, 8'h6F);
    pulse(7'h10);
    check("dma_idle", 8'h00, 8'(dma_in_progress));
    check("no_irq", 8'h00, 8'(interrupt_request_out));
    rd_check("done", `OFS_INTERRUPT_PENDING, 8'h10);
    i_cpu_port_model.write_reg(`OFS_INTERRUPT_MASK, 8'h10);
    check("done_irq", 8'h01, 8'(interrupt_request_out));
    // Mid-run reset with J forced, request high and address loaded
    i_cpu_port_model.write_reg(`OFS_MAIN_CONTROL, 8'h18);
    check("line_j", 8'(LINE_J), 8'(line_state));
    @(negedge clk);
    sys_rst = 1'h1;
    repeat (20) @(negedge clk);
    sys_rst = 1'h0;
    check("ctl_rst2", 8'h00, {1'h0, main_ctrl});
    check("line_rst2", 8'(LINE_NORMAL), 8'(line_state));
    check("addr_rst2", 8'h00, device_address);
    check("irq_rst2", 8'h00, 8'(interrupt_request_out));
    rd_check("pend_rst2", `OFS_INTERRUPT_PENDING, 8'h00);
    rd_check("addr_rd2", `OFS_DEVICE_BUS_ADDRESS, 8'h00);
    close_out();
  end
endmodule
